// *** design/ide_cs_pkg.sv ***
// Constants shared by the IDE chip-select decoder and its select slices.
// Assumes a single core clock domain and a plain register strobe port.

`default_nettype none

package ide_cs_pkg;

    localparam int ADDR_W     = 16;
    localparam int LOW_ADDR_W = 12;
    localparam int REG_ADDR_W = 8;
    localparam int DATA_W     = 8;
    localparam int SELECT_CNT = 4;
    localparam int PIN_CNT    = 19;

    // Register map, shared offsets split by logical unit
    localparam logic                  UNIT_CHAN1     = 1'h0;
    localparam logic                  UNIT_CHAN2     = 1'h1;
    localparam logic [REG_ADDR_W-1:0] SELECT0_OFFSET = 8'hF0;
    localparam logic [REG_ADDR_W-1:0] SELECT1_OFFSET = 8'hF1;
    localparam logic [REG_ADDR_W-1:0] MODE_OFFSET    = 8'hF0;

    localparam logic [DATA_W-1:0] SELECT0_RESET = 8'h0C;
    localparam logic [DATA_W-1:0] SELECT1_RESET = 8'h00;
    localparam logic [DATA_W-1:0] MODE_RESET    = 8'h00;

    // Field layout of a select register
    localparam int QUAL_LSB      = 0;
    localparam int QUAL_MSB      = 1;
    localparam int MASK_LSB      = 2;
    localparam int MASK_MSB      = 4;
    localparam int MODE_SHARE    = 0;
    localparam logic [DATA_W-1:0] SELECT_WR_MASK = 8'h1F;
    localparam logic [DATA_W-1:0] MODE_WR_MASK   = 8'h01;

    localparam logic [2:0] MASK_FIRST_RESERVED = 3'h6;

    // Upper address bits: SA12 on the general select pin, SA13..SA15 on shared pins
    localparam int SA12_BIT = 12;
    localparam int SA13_BIT = 13;
    localparam int SA15_BIT = 15;

    typedef enum logic [1:0] {
        QUAL_AEN   = 2'h0,
        QUAL_READ  = 2'h1,
        QUAL_WRITE = 2'h2,
        QUAL_EITHER = 2'h3
    } qualifier_type;

    // Channel-two selects have no decode register; fixed exact match
    localparam logic [DATA_W-1:0] CHAN2_DECODE_CONFIG = 8'h03;

endpackage

`default_nettype wire

// *** design/select_decode_if.sv ***
// Carrier between the top decoder and one select slice.
// Assumes all members are on the core clock; slice is combinational.

`default_nettype none

interface select_decode_if;
    logic [ide_cs_pkg::ADDR_W-1:0] base;
    logic [ide_cs_pkg::ADDR_W-1:0] addr;
    logic [ide_cs_pkg::DATA_W-1:0] decodeConfig;
    logic                          wide;
    logic                          aen;
    logic                          readN;
    logic                          writeN;
    logic                          hit;

    modport client (
        output base,
        output addr,
        output decodeConfig,
        output wide,
        output aen,
        output readN,
        output writeN,
        input  hit
    );

    modport decoder (
        input  base,
        input  addr,
        input  decodeConfig,
        input  wide,
        input  aen,
        input  readN,
        input  writeN,
        output hit
    );
endinterface

`default_nettype wire

// *** design/select_decoder.sv ***
// One chip-select slice: masked address compare plus strobe qualifier.
// Assumes synchronised host signals; result is registered by the caller.

`default_nettype none

module select_decoder (
    select_decode_if.decoder sel
);

    logic [2:0]                    maskCode;
    logic [1:0]                    qualCode;
    logic [ide_cs_pkg::ADDR_W-1:0] careMask;
    logic                          addrMatch;
    logic                          qualOk;
    logic                          reservedCode;

    assign maskCode = sel.decodeConfig[ide_cs_pkg::MASK_MSB:
                                       ide_cs_pkg::MASK_LSB];
    assign qualCode = sel.decodeConfig[ide_cs_pkg::QUAL_MSB:
                                       ide_cs_pkg::QUAL_LSB];

    always_comb begin
        careMask = {ide_cs_pkg::ADDR_W{1'b1}} << maskCode;
        // Narrow mode: SA13..SA15 are not present, so not compared
        if (!sel.wide) begin
            careMask[ide_cs_pkg::SA15_BIT:ide_cs_pkg::SA13_BIT] = 3'h0;
        end
    end

    // Reserved codes never select, so a bad program stays harmless
    assign reservedCode = maskCode >= ide_cs_pkg::MASK_FIRST_RESERVED;

    assign addrMatch = ((sel.addr ^ sel.base) & careMask) == '0;

    always_comb begin
        case (qualCode)
            ide_cs_pkg::QUAL_AEN: begin
                qualOk = !sel.aen;
            end
            ide_cs_pkg::QUAL_READ: begin
                qualOk = !sel.aen && !sel.readN;
            end
            ide_cs_pkg::QUAL_WRITE: begin
                qualOk = !sel.aen && !sel.writeN;
            end
            default: begin
                qualOk = !sel.aen && (!sel.readN || !sel.writeN);
            end
        endcase
    end

    assign sel.hit = addrMatch && qualOk && !reservedCode;

endmodule

`default_nettype wire

// *** design/ide_chip_select_decoder.sv ***
// Top of the IDE chip-select decoder for two drive channels.
// Assumes host pins are asynchronous to core_clk; base addresses, active
// bit and wide-address setting come from core_clk configuration logic.
//
// Local design decision: the address-and-strobe port.

`default_nettype none

module ide_chip_select_decoder #(
    parameter int SYNC_STAGES = 2
) (
    // Clock and resets
    input  wire logic                              core_clk,
    input  wire logic                              reset,
    input  wire logic                              softReset,

    // Register port
    input  wire logic                              regUnit,
    input  wire logic [ide_cs_pkg::REG_ADDR_W-1:0] regAddr,
    input  wire logic [ide_cs_pkg::DATA_W-1:0]     regWrData,
    input  wire logic                              regWrite,
    input  wire logic                              regRead,
    output logic      [ide_cs_pkg::DATA_W-1:0]     regRdData,

    // Configuration from elsewhere
    input  wire logic [ide_cs_pkg::ADDR_W-1:0]     chan1Base0,
    input  wire logic [ide_cs_pkg::ADDR_W-1:0]     chan1Base1,
    input  wire logic [ide_cs_pkg::ADDR_W-1:0]     chan2Base0,
    input  wire logic [ide_cs_pkg::ADDR_W-1:0]     chan2Base1,
    input  wire logic                              chan2Active,
    input  wire logic                              wideAddressDecode,

    // Host bus pins
    input  wire logic [ide_cs_pkg::LOW_ADDR_W-1:0] hostAddr,
    input  wire logic                              hostAen,
    input  wire logic                              hostReadN,
    input  wire logic                              hostWriteN,
    input  wire logic                              generalSelectN,

    // Channel-one drive pins
    output logic                                   driveSelectPrimaryN,
    output logic                                   driveSelectSecondaryN,
    output logic                                   chan1BufferEnableN,

    // Channel-two shared pins
    input  wire logic                              chan2SelectAIn,
    output logic                                   chan2SelectAOutN,
    output logic                                   chan2SelectAOe,
    input  wire logic                              chan2SelectBIn,
    output logic                                   chan2SelectBOutN,
    output logic                                   chan2SelectBOe,
    input  wire logic                              chan2InterruptIn,
    output logic                                   chan2InterruptOut,
    output logic                                   chan2InterruptOe,
    output logic                                   chan2BufferEnableN,
    output logic                                   chan2DriveInterrupt
);

    if (SYNC_STAGES < 2) begin : gStageCheck
        $error("SYNC_STAGES must be at least 2");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    localparam int PW = ide_cs_pkg::PIN_CNT;
    // AEN and strobes idle high, so no false decode follows reset
    localparam logic [PW-1:0] PIN_IDLE = PW'(3'h7) << ide_cs_pkg::LOW_ADDR_W;

    logic [PW-1:0] pinRaw;
    logic [PW-1:0] pinStage_q [SYNC_STAGES];
    logic [PW-1:0] pinSync;

    assign pinRaw = {chan2InterruptIn, chan2SelectBIn, chan2SelectAIn,
                     generalSelectN, hostWriteN, hostReadN, hostAen,
                     hostAddr};

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pinStage_q[0] <= PIN_IDLE;
        end else begin
            pinStage_q[0] <= pinRaw;
        end
    end

    for (genvar s = 1; s < SYNC_STAGES; s++) begin : gSync
        always_ff @(posedge core_clk) begin
            if (reset) begin
                pinStage_q[s] <= PIN_IDLE;
            end else begin
                pinStage_q[s] <= pinStage_q[s-1];
            end
        end
    end

    assign pinSync = pinStage_q[SYNC_STAGES-1];

    logic [ide_cs_pkg::LOW_ADDR_W-1:0] addrLow;
    logic                              aenSync;
    logic                              readNSync;
    logic                              writeNSync;
    logic                              sa12Sync;
    logic [2:0]                        sharedSync;

    assign addrLow    = pinSync[ide_cs_pkg::LOW_ADDR_W-1:0];
    assign aenSync    = pinSync[ide_cs_pkg::LOW_ADDR_W];
    assign readNSync  = pinSync[ide_cs_pkg::LOW_ADDR_W+1];
    assign writeNSync = pinSync[ide_cs_pkg::LOW_ADDR_W+2];
    assign sa12Sync   = pinSync[ide_cs_pkg::LOW_ADDR_W+3];
    assign sharedSync = pinSync[PW-1:PW-3];

    ////////////////////////////////////////////////////////////////////////
    // Pin roles and the full host address

    logic                          wideInputs;
    logic [2:0]                    upperAddr;
    logic [ide_cs_pkg::ADDR_W-1:0] fullAddr;

    // Shared pins only carry address while channel two is idle
    assign wideInputs = !chan2Active && wideAddressDecode;
    assign upperAddr  = wideInputs ? sharedSync : 3'h0;

    // General select pin is always SA12
    assign fullAddr = {upperAddr, sa12Sync, addrLow};

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [ide_cs_pkg::DATA_W-1:0] select0_q;
    logic [ide_cs_pkg::DATA_W-1:0] select1_q;
    logic [ide_cs_pkg::DATA_W-1:0] mode_q;
    logic [ide_cs_pkg::DATA_W-1:0] regRdData_q;
    logic [ide_cs_pkg::DATA_W-1:0] readMux;
    logic                          hitSel0;
    logic                          hitSel1;
    logic                          hitMode;

    assign hitSel0 = regUnit == ide_cs_pkg::UNIT_CHAN1 &&
                     regAddr == ide_cs_pkg::SELECT0_OFFSET;
    assign hitSel1 = regUnit == ide_cs_pkg::UNIT_CHAN1 &&
                     regAddr == ide_cs_pkg::SELECT1_OFFSET;
    assign hitMode = regUnit == ide_cs_pkg::UNIT_CHAN2 &&
                     regAddr == ide_cs_pkg::MODE_OFFSET;

    // Software reset restores decode windows but not the buffer mode
    always_ff @(posedge core_clk) begin
        if (reset || softReset) begin
            select0_q <= ide_cs_pkg::SELECT0_RESET;
            select1_q <= ide_cs_pkg::SELECT1_RESET;
        end else if (regWrite) begin
            if (hitSel0) begin
                select0_q <= regWrData & ide_cs_pkg::SELECT_WR_MASK;
            end
            if (hitSel1) begin
                select1_q <= regWrData & ide_cs_pkg::SELECT_WR_MASK;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            mode_q <= ide_cs_pkg::MODE_RESET;
        end else if (regWrite && hitMode) begin
            mode_q <= regWrData & ide_cs_pkg::MODE_WR_MASK;
        end
    end

    always_comb begin
        readMux = '0;
        if (hitSel0) begin
            readMux = select0_q;
        end else if (hitSel1) begin
            readMux = select1_q;
        end else if (hitMode) begin
            readMux = mode_q;
        end
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge core_clk) begin
        if (reset) begin
            regRdData_q <= '0;
        end else if (regRead) begin
            regRdData_q <= readMux;
        end else begin
            regRdData_q <= '0;
        end
    end

    assign regRdData = regRdData_q;

    ////////////////////////////////////////////////////////////////////////
    // Select slices: 0/1 channel one, 2/3 channel two

    localparam int SN = ide_cs_pkg::SELECT_CNT;

    logic [ide_cs_pkg::ADDR_W-1:0] selBase   [SN];
    logic [ide_cs_pkg::DATA_W-1:0] selConfig [SN];
    logic [SN-1:0]                 selHit;

    assign selBase[0]   = chan1Base0;
    assign selBase[1]   = chan1Base1;
    assign selBase[2]   = chan2Base0;
    assign selBase[3]   = chan2Base1;
    assign selConfig[0] = select0_q;
    assign selConfig[1] = select1_q;
    assign selConfig[2] = ide_cs_pkg::CHAN2_DECODE_CONFIG;
    assign selConfig[3] = ide_cs_pkg::CHAN2_DECODE_CONFIG;

    for (genvar i = 0; i < SN; i++) begin : gSel
        select_decode_if selIf ();

        assign selIf.base         = selBase[i];
        assign selIf.addr         = fullAddr;
        assign selIf.decodeConfig = selConfig[i];
        assign selIf.wide         = wideInputs;
        assign selIf.aen          = aenSync;
        assign selIf.readN        = readNSync;
        assign selIf.writeN       = writeNSync;
        assign selHit[i]          = selIf.hit;

        select_decoder uDecoder (
            .sel (selIf.decoder)
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Chip select outputs

    logic chan2Hit;

    // Channel two cannot select while its pins are address inputs
    assign chan2Hit = chan2Active && (selHit[2] || selHit[3]);

    logic driveSelectPrimaryN_q;
    logic driveSelectSecondaryN_q;
    logic chan2SelectAOutN_q;
    logic chan2SelectBOutN_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            driveSelectPrimaryN_q   <= 1'b1;
            driveSelectSecondaryN_q <= 1'b1;
            chan2SelectAOutN_q      <= 1'b1;
            chan2SelectBOutN_q      <= 1'b1;
        end else begin
            driveSelectPrimaryN_q   <= !selHit[0];
            driveSelectSecondaryN_q <= !selHit[1];
            chan2SelectAOutN_q      <= !(chan2Active && selHit[2]);
            chan2SelectBOutN_q      <= !(chan2Active && selHit[3]);
        end
    end

    assign driveSelectPrimaryN   = driveSelectPrimaryN_q;
    assign driveSelectSecondaryN = driveSelectSecondaryN_q;
    assign chan2SelectAOutN      = chan2SelectAOutN_q;
    assign chan2SelectBOutN      = chan2SelectBOutN_q;

    ////////////////////////////////////////////////////////////////////////
    // Pin direction control

    logic chan2SelectAOe_q;
    logic chan2SelectBOe_q;
    logic chan2InterruptOut_q;
    logic chan2InterruptOe_q;

    // Drive only when active; otherwise high-Z or address input
    always_ff @(posedge core_clk) begin
        if (reset) begin
            chan2SelectAOe_q <= 1'b0;
            chan2SelectBOe_q <= 1'b0;
        end else begin
            chan2SelectAOe_q <= chan2Active;
            chan2SelectBOe_q <= chan2Active;
        end
    end

    // Interrupt pin is never driven: input or high-Z in every mode
    always_ff @(posedge core_clk) begin
        if (reset) begin
            chan2InterruptOut_q <= 1'b0;
            chan2InterruptOe_q  <= 1'b0;
        end else begin
            chan2InterruptOut_q <= 1'b0;
            chan2InterruptOe_q  <= 1'b0;
        end
    end

    assign chan2SelectAOe    = chan2SelectAOe_q;
    assign chan2SelectBOe    = chan2SelectBOe_q;
    assign chan2InterruptOut = chan2InterruptOut_q;
    assign chan2InterruptOe  = chan2InterruptOe_q;

    logic chan2DriveInterrupt_q;

    // Pin carries SA15 in wide mode, so pass it on only when active
    always_ff @(posedge core_clk) begin
        if (reset) begin
            chan2DriveInterrupt_q <= 1'b0;
        end else begin
            chan2DriveInterrupt_q <= chan2Active && sharedSync[2];
        end
    end

    assign chan2DriveInterrupt = chan2DriveInterrupt_q;

    ////////////////////////////////////////////////////////////////////////
    // Data buffer enables, active low

    logic shareBuffer;
    logic chan1BufferEnableN_q;
    logic chan2BufferEnableN_q;

    assign shareBuffer = mode_q[ide_cs_pkg::MODE_SHARE];

    always_ff @(posedge core_clk) begin
        if (reset) begin
            chan1BufferEnableN_q <= 1'b1;
            chan2BufferEnableN_q <= 1'b1;
        end else begin
            chan1BufferEnableN_q <= !((selHit[0] || selHit[1]) ||
                                      (shareBuffer && chan2Hit));
            chan2BufferEnableN_q <= !(!shareBuffer && chan2Hit);
        end
    end

    assign chan1BufferEnableN = chan1BufferEnableN_q;
    assign chan2BufferEnableN = chan2BufferEnableN_q;

endmodule

`default_nettype wire

// *** dv/ide_chip_select_decoder_assertions.sv ***
// Port-level checks for the IDE chip-select decoder.
// Assumes binding into the decoder top; one clock, sync active-high reset.

`default_nettype none

module ide_chip_select_decoder_assertions #(
    parameter int SYNC_STAGES = 2
) (
    // Clock and reset
    input wire logic                          core_clk,
    input wire logic                          reset,
    // Register port
    input wire logic                          regUnit,
    input wire logic [ide_cs_pkg::REG_ADDR_W-1:0] regAddr,
    input wire logic [ide_cs_pkg::DATA_W-1:0] regWrData,
    input wire logic                          regWrite,
    input wire logic                          regRead,
    input wire logic [ide_cs_pkg::DATA_W-1:0] regRdData,
    // Configuration and host
    input wire logic                          chan2Active,
    input wire logic                          hostAen,
    // Drive pins
    input wire logic                          driveSelectPrimaryN,
    input wire logic                          driveSelectSecondaryN,
    input wire logic                          chan1BufferEnableN,
    input wire logic                          chan2SelectAOutN,
    input wire logic                          chan2SelectBOutN,
    input wire logic                          chan2SelectAOe,
    input wire logic                          chan2SelectBOe,
    input wire logic                          chan2InterruptOe,
    input wire logic                          chan2BufferEnableN,
    input wire logic                          chan2DriveInterrupt
);
    timeunit 1ns;
    timeprecision 1ps;

    // Shadow of the sharing bit, kept from the write strobes alone
    logic modeQ;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            modeQ <= 1'b0;
        end else if (regWrite && regUnit
                     && regAddr == ide_cs_pkg::MODE_OFFSET) begin
            modeQ <= regWrData[ide_cs_pkg::MODE_SHARE];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_aen_blocks: assert property (hostAen [*5] |->
        driveSelectPrimaryN && driveSelectSecondaryN && chan2SelectAOutN)
        else $error("select asserted while AEN high");
    a_chan2_quiet: assert property (!chan2Active [*2] |->
        chan2SelectAOutN && chan2SelectBOutN)
        else $error("channel-two select while inactive");
    a_oe_tracks: assert property (!$past(reset) |->
        chan2SelectAOe == $past(chan2Active)
        && chan2SelectBOe == $past(chan2Active))
        else $error("select enable not following active bit");
    a_irq_undriven: assert property (!chan2InterruptOe)
        else $error("interrupt pin driven");
    a_irq_gated: assert property (!chan2Active [*2] |->
        !chan2DriveInterrupt)
        else $error("interrupt forwarded while inactive");
    a_read_stands: assert property (regRdData != 8'h00 |->
        $past(regRead))
        else $error("read data outside its cycle");
    a_buf1_cover: assert property (
        (!driveSelectPrimaryN || !driveSelectSecondaryN)
        |-> !chan1BufferEnableN)
        else $error("channel-one buffer off during select");
    a_buf2_unused: assert property (modeQ && $past(modeQ) |->
        chan2BufferEnableN)
        else $error("channel-two buffer used while shared");
    a_buf2_own: assert property (
        !chan2SelectAOutN && !modeQ && !$past(modeQ)
        |-> !chan2BufferEnableN)
        else $error("channel-two buffer off during select");
endmodule

`default_nettype wire

// *** dv/isa_host_model.sv ***
// Host bus and drive-side pin model for the IDE chip-select decoder.
// Assumes the bench sets one host cycle at a time on the cyc inputs.

`default_nettype none

module isa_host_model (
    // Clock
    input wire logic        core_clk,
    // Cycle requested by the bench
    input wire logic [15:0] cycAddr,
    input wire logic        cycAen,
    input wire logic        cycReadN,
    input wire logic        cycWriteN,
    input wire logic        irqLevel,
    input wire logic        wideAddressDecode,
    input wire logic        chan2Active,
    // Design drive of the shared pins
    input wire logic        chan2SelectAOutN,
    input wire logic        chan2SelectAOe,
    input wire logic        chan2SelectBOutN,
    input wire logic        chan2SelectBOe,
    // Pin levels seen by the design
    output logic     [11:0] hostAddr,
    output logic            hostAen,
    output logic            hostReadN,
    output logic            hostWriteN,
    output logic            generalSelectN,
    output logic            chan2SelectAIn,
    output logic            chan2SelectBIn,
    output logic            chan2InterruptIn
);
    timeunit 1ns;
    timeprecision 1ps;

    // Floating pins toggle so a stale level can never look valid
    logic flip = 1'b0;

    always @(posedge core_clk) begin
        flip <= !flip;
    end

    assign hostAddr = cycAddr[11:0];
    assign hostAen = cycAen;
    assign hostReadN = cycReadN;
    assign hostWriteN = cycWriteN;
    assign generalSelectN = cycAddr[12];
    assign chan2SelectAIn = chan2SelectAOe ? chan2SelectAOutN
        : (wideAddressDecode ? cycAddr[13] : flip);
    assign chan2SelectBIn = chan2SelectBOe ? chan2SelectBOutN
        : (wideAddressDecode ? cycAddr[14] : flip);
    assign chan2InterruptIn = chan2Active ? irqLevel
        : (wideAddressDecode ? cycAddr[15] : flip);
endmodule

`default_nettype wire

// *** dv/ide_chip_select_decoder_test.sv ***
// Self-checking bench for the IDE chip-select decoder.
// Assumes the host model and checker files are compiled before this one.

`default_nettype none

module ide_chip_select_decoder_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        softReset = 1'b0;
    logic        regUnit = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [7:0]  regWrData = 8'h00;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic [7:0]  regRdData;
    logic [15:0] chan1Base0 = 16'h01e0;
    logic [15:0] chan1Base1 = 16'ha1f8;
    logic [15:0] chan2Base0 = 16'h0170;
    logic [15:0] chan2Base1 = 16'h0376;
    logic        chan2Active = 1'b0;
    logic        wideAddressDecode = 1'b0;
    logic [15:0] cycAddr = 16'h0000;
    logic        cycAen = 1'b1;
    logic        cycReadN = 1'b1;
    logic        cycWriteN = 1'b1;
    logic        irqLevel = 1'b0;
    logic [11:0] hostAddr;
    logic        hostAen, hostReadN, hostWriteN, generalSelectN;
    logic        driveSelectPrimaryN, driveSelectSecondaryN;
    logic        chan1BufferEnableN, chan2BufferEnableN;
    logic        chan2SelectAIn, chan2SelectAOutN, chan2SelectAOe;
    logic        chan2SelectBIn, chan2SelectBOutN, chan2SelectBOe;
    logic        chan2InterruptIn, chan2InterruptOut, chan2InterruptOe;
    logic        chan2DriveInterrupt;
    int          nErrors = 0;
    int          testsRun = 0;
    int          cycles = 0;

    ide_chip_select_decoder #(.SYNC_STAGES(2)) u_dut (.*);
    isa_host_model u_host (.*);

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic stopTest();
        $display("checks %0d mismatches %0d", testsRun, nErrors);
        if (nErrors == 0 && testsRun > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        testsRun++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value at %0t: %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chkBit(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask

    task automatic wrReg(input logic u, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regUnit <= u;
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask

    task automatic rdChk(input logic u, input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        regUnit <= u;
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1;
        chk8(regRdData, e);
    endtask

    // Host cycle held long enough for sync plus output flop
    task automatic cyc(input logic [15:0] a, input logic aen,
                       input logic rdN, input logic wrN);
        @(posedge core_clk);
        cycAddr <= a;
        cycAen <= aen;
        cycReadN <= rdN;
        cycWriteN <= wrN;
        repeat (4) @(posedge core_clk);
        #1;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            nErrors++;
            stopTest();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        rdChk(1'b0, 8'hf0, 8'h0c);
        rdChk(1'b0, 8'hf1, 8'h00);
        rdChk(1'b1, 8'hf0, 8'h00);
        rdChk(1'b1, 8'hf1, 8'h00);
        wrReg(1'b0, 8'hf0, 8'hff);
        rdChk(1'b0, 8'hf0, 8'h1f);
        // Last byte of each window hits for codes 0..5 (6 and 7 are reserved, never hit), next byte misses
        for (int m = 0; m < 8; m++) begin
            wrReg(1'b0, 8'hf0, 8'(m << 2));
            cyc(chan1Base0 + 16'((1 << m) - 1), 1'b0, 1'b1, 1'b1);
            chkBit(driveSelectPrimaryN, m > 5);
            chkBit(chan1BufferEnableN, m > 5);
            cyc(chan1Base0 + 16'(1 << m), 1'b0, 1'b1, 1'b1);
            chkBit(driveSelectPrimaryN, 1'b1);
        end
        for (int q = 0; q < 4; q++) begin
            wrReg(1'b0, 8'hf1, 8'(q));
            for (int k = 0; k < 3; k++) begin
                cyc(chan1Base1, 1'b0, k != 1, k != 2);
                chkBit(driveSelectSecondaryN, !(q == 0 || (q & k) != 0));
            end
            cyc(chan1Base1, 1'b1, 1'b0, 1'b1);
            chkBit(driveSelectSecondaryN, 1'b1);
        end
        wrReg(1'b1, 8'hf0, 8'h01);
        @(posedge core_clk);
        softReset <= 1'b1;
        @(posedge core_clk);
        softReset <= 1'b0;
        rdChk(1'b0, 8'hf0, 8'h0c);
        rdChk(1'b0, 8'hf1, 8'h00);
        rdChk(1'b1, 8'hf0, 8'h01);
        @(posedge core_clk);
        chan2Active <= 1'b1;
        irqLevel <= 1'b1;
        cyc(chan2Base0, 1'b0, 1'b0, 1'b1);
        chkBit(chan2SelectAOutN, 1'b0);
        chkBit(chan2BufferEnableN, 1'b1);
        chkBit(chan1BufferEnableN, 1'b0);
        chkBit(chan2DriveInterrupt, 1'b1);
        chkBit(chan2SelectBOe, 1'b1);
        chkBit(chan2InterruptOut, 1'b0);
        wrReg(1'b1, 8'hf0, 8'h00);
        cyc(chan2Base1, 1'b0, 1'b1, 1'b0);
        chkBit(chan2SelectBOutN, 1'b0);
        chkBit(chan2BufferEnableN, 1'b0);
        chkBit(chan1BufferEnableN, 1'b1);
        @(posedge core_clk);
        chan2Active <= 1'b0;
        cyc(chan2Base0, 1'b0, 1'b0, 1'b1);
        chkBit(chan2SelectAOutN, 1'b1);
        chkBit(chan2SelectAOe, 1'b0);
        chkBit(chan2DriveInterrupt, 1'b0);
        // SA13..SA15 take part in the compare only when wide; SA12 always does
        @(posedge core_clk);
        wideAddressDecode <= 1'b1;
        cyc(chan1Base1, 1'b0, 1'b1, 1'b1);
        chkBit(driveSelectSecondaryN, 1'b0);
        for (int b = 12; b < 16; b++) begin
            cyc(chan1Base1 ^ 16'(1 << b), 1'b0, 1'b1, 1'b1);
            chkBit(driveSelectSecondaryN, 1'b1);
        end
        stopTest();
    end
endmodule

bind ide_chip_select_decoder ide_chip_select_decoder_assertions #(
    .SYNC_STAGES(SYNC_STAGES)) u_chk (.*);

`default_nettype wire
